// >>> hw/tic_pkg.sv
// Constants, field layouts and types of the triple interval counter.
// Assumes a 20 MHz APB clock; shared by the counter top module, the checker and the testbench.
package tic_pkg;

  // ******************************************************************
  // Register map (byte addresses)
  // ******************************************************************
  localparam logic [7:0] OFF_CNT0   = 8'h00;
  localparam logic [7:0] OFF_CNT1   = 8'h04;
  localparam logic [7:0] OFF_CNT2   = 8'h08;
  localparam logic [7:0] OFF_SETUP  = 8'h0C;
  localparam logic [7:0] OFF_CLKSEL = 8'h10;

  // ******************************************************************
  // Setup byte and clock select fields
  // ******************************************************************
  localparam int SEL_HI      = 7;
  localparam int SEL_LO      = 6;
  localparam int FMT_HI      = 5;
  localparam int FMT_LO      = 4;
  localparam int MODE_HI     = 3;
  localparam int MODE_LO     = 1;
  localparam int BCD_BIT     = 0;
  localparam int RB_CNT_N    = 5;
  localparam int RB_STA_N    = 4;
  localparam int RB_PICK_LO  = 1;
  localparam int CLKSEL_EXT  = 0;

  localparam logic [1:0] SEL_READBACK = 2'b11;
  localparam logic [1:0] FMT_LATCH    = 2'b00;
  localparam logic [1:0] FMT_LOW      = 2'b01;
  localparam logic [1:0] FMT_HIGH     = 2'b10;
  localparam logic [1:0] FMT_LOHI     = 2'b11;

  localparam logic [2:0] MODE0 = 3'h0;
  localparam logic [2:0] MODE1 = 3'h1;
  localparam logic [2:0] MODE2 = 3'h2;
  localparam logic [2:0] MODE3 = 3'h3;
  localparam logic [2:0] MODE4 = 3'h4;
  localparam logic [2:0] MODE5 = 3'h5;

  // ******************************************************************
  // Values and timing
  // ******************************************************************
  localparam logic [15:0] ZERO16    = 16'h0000;
  localparam logic [15:0] ONE16     = 16'h0001;
  localparam logic [15:0] TWO16     = 16'h0002;
  localparam logic [3:0]  DIGIT_MAX = 4'h9;
  localparam logic [7:0]  ZERO8     = 8'h00;
  localparam logic        OUT_RST   = 1'b0;

  localparam int PCLK_HZ    = 20_000_000;
  localparam int INT_CLK_HZ = 10_000_000;
  localparam int INT_HALF   = PCLK_HZ / (2 * INT_CLK_HZ);

  typedef struct packed {
    logic [1:0] fmt;
    logic [2:0] mode;
    logic       bcd;
  } tic_cfg_t;

  localparam tic_cfg_t CFG_RST = '{fmt: FMT_LOW, mode: MODE0, bcd: 1'b0};

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_RUN, ST_DONE} tic_state_t;

endpackage

// >>> hw/tic_top.sv
// Three 16-bit presettable down-counters behind an APB slave.
// Assumes clock, gate and pin inputs synchronous to pclk; pin clocks
// must stay below pclk/2 so every rising edge is seen.
//
// How it works
// R1: three 16-bit down-counters, own clock, gate, output
// R2: counts 2..65535; output is clock over count
// R3: counter 1 output clocks counter 2
// R4: counter 2 output drives conversion start
// R5: counter 0 clock: internal 10MHz or pin
// R6: gate rising edge triggers; clock edge steps
// R7: mode 0 low from load until zero
// R8: mode 1 retriggerable low one-shot
// R9: mode 2 one-clock low pulse every N
// R10: mode 3 square wave, odd split high-first
// R11: mode 3 steps by two each half
// R12: mode 4 one low pulse after load
// R13: mode 4 low gate holds count
// R14: mode 5 gate-triggered retriggerable strobe
// R15: setup byte: select, format, mode, BCD
// R16: select 11 means read-back command
// R17: format: latch, low, high, low-then-high
// R18: modes 2 and 3 ignore top bit
// R19: bit 0 picks binary or BCD counting
// R20: three count locations plus write-only setup
// R21: latch copies count into hold register
// R22: byte-order flop pairs low/high accesses
// R23: read-back latches counts and/or status
// R24: status byte: output, null count, setup
// R25: modes 0, 2, 3 pause while gate low
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module tic_top
  import tic_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ext_clk0,
  input  wire logic              clk1_in,
  input  wire logic [2:0]        gate,
  output logic      [2:0]        cnt_out,
  output logic                   adc_start
);
  import tic_pkg::*;

  if (ADDR_W < 5) begin : g_chk
    $error("tic_top: ADDR_W must be at least 5");
  end

  // ******************************************************************
  // Helpers
  // ******************************************************************
  function automatic logic [15:0] dec1(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic        borrow;
    r      = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - ONE16;
    end else begin
      for (int d = 0; d < 4; d++) begin
        if (borrow) begin
          if (r[d*4+:4] == 4'h0) begin
            r[d*4+:4] = DIGIT_MAX;
          end else begin
            r[d*4+:4] = r[d*4+:4] - 4'h1;
            borrow    = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] eff_mode(input logic [2:0] m);
    return m[MODE_LO] ? {1'b0, m[1:0]} : m; // R18
  endfunction

  function automatic logic [7:0] pick_byte(input logic [15:0] v, input logic [1:0] f,
                                           input logic flop);
    logic hi;
    hi = (f == FMT_HIGH) || ((f == FMT_LOHI) && flop);
    return hi ? v[15:8] : v[7:0];
  endfunction

  // ******************************************************************
  // State
  // ******************************************************************
  tic_cfg_t    cfg_r     [3];
  logic [15:0] reload_r  [3];
  logic [15:0] hold_r    [3];
  logic [15:0] cnt_r     [3];
  logic [7:0]  status_r  [3];
  tic_state_t  st_r      [3];
  logic [2:0]  wflop_r;
  logic [2:0]  rflop_r;
  logic [2:0]  cnt_l_r;
  logic [2:0]  sta_l_r;
  logic [2:0]  out_r;
  logic [2:0]  null_r;
  logic [2:0]  have_r;
  logic [2:0]  trig_r;
  logic [2:0]  extra_r;
  logic [2:0]  gate_q_r;
  logic [2:0]  clk_q_r;
  logic        clksel_r;
  logic        int_clk_r;
  logic [3:0]  div_r;
  logic [31:0] prdata_r;

  logic [2:0]  clk_src;
  logic [2:0]  tick;
  logic [2:0]  rise;
  logic [2:0]  wr_ctl;
  logic [2:0]  wr_first;
  logic [2:0]  wr_done;
  logic        acc;
  logic        hit_cnt;
  logic [1:0]  hit_idx;
  logic        hit_setup;
  logic        hit_clksel;
  logic        mapped;
  logic [7:0]  wbyte;

  // ******************************************************************
  // APB decode
  // ******************************************************************
  always_comb begin
    hit_cnt    = 1'b0;
    hit_idx    = 2'd0;
    hit_setup  = 1'b0;
    hit_clksel = 1'b0;
    if (paddr == ADDR_W'(OFF_CNT0)) begin // R20
      hit_cnt = 1'b1;
    end else if (paddr == ADDR_W'(OFF_CNT1)) begin
      hit_cnt = 1'b1;
      hit_idx = 2'd1;
    end else if (paddr == ADDR_W'(OFF_CNT2)) begin
      hit_cnt = 1'b1;
      hit_idx = 2'd2;
    end else if (paddr == ADDR_W'(OFF_SETUP)) begin
      hit_setup = 1'b1;
    end else if (paddr == ADDR_W'(OFF_CLKSEL)) begin
      hit_clksel = 1'b1;
    end
  end

  assign mapped  = hit_cnt | hit_setup | hit_clksel;
  assign acc     = psel & penable;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = prdata_r;
  assign wbyte   = pwdata[7:0];

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      wr_ctl[i]   = acc & pwrite & hit_setup & (wbyte[SEL_HI:SEL_LO] == 2'(i)) &
                    (wbyte[FMT_HI:FMT_LO] != FMT_LATCH); // R15 R16
      wr_first[i] = acc & pwrite & hit_cnt & (hit_idx == 2'(i)) &
                    (cfg_r[i].fmt == FMT_LOHI) & ~wflop_r[i];
      wr_done[i]  = acc & pwrite & hit_cnt & (hit_idx == 2'(i)) &
                    ((cfg_r[i].fmt != FMT_LOHI) | wflop_r[i]);
    end
  end

  // Read data is captured in the setup cycle; side effects wait for the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= '0;
      if (hit_cnt) begin
        if (sta_l_r[hit_idx]) begin
          prdata_r[7:0] <= status_r[hit_idx];
        end else if (cnt_l_r[hit_idx]) begin
          prdata_r[7:0] <= pick_byte(hold_r[hit_idx], cfg_r[hit_idx].fmt,
                                     rflop_r[hit_idx]); // R21
        end else begin
          prdata_r[7:0] <= pick_byte(cnt_r[hit_idx], cfg_r[hit_idx].fmt,
                                     rflop_r[hit_idx]);
        end
      end else if (hit_clksel) begin
        prdata_r[CLKSEL_EXT] <= clksel_r;
      end
    end
  end

  // ******************************************************************
  // Software-side registers
  // ******************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clksel_r <= 1'b0;
    end else if (acc && pwrite && hit_clksel) begin
      clksel_r <= pwdata[CLKSEL_EXT]; // R5
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        cfg_r[i]    <= CFG_RST;
        reload_r[i] <= ZERO16;
        hold_r[i]   <= ZERO16;
        status_r[i] <= ZERO8;
      end
      wflop_r <= '0;
      rflop_r <= '0;
      cnt_l_r <= '0;
      sta_l_r <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (acc && pwrite && hit_setup) begin
          if (wbyte[SEL_HI:SEL_LO] == 2'(i)) begin
            if (wbyte[FMT_HI:FMT_LO] == FMT_LATCH) begin
              // A pending latch is kept until read out
              if (!cnt_l_r[i]) begin
                hold_r[i]  <= cnt_r[i]; // R17 R21
                cnt_l_r[i] <= 1'b1;
              end
            end else begin
              cfg_r[i].fmt  <= wbyte[FMT_HI:FMT_LO]; // R17
              cfg_r[i].mode <= wbyte[MODE_HI:MODE_LO];
              cfg_r[i].bcd  <= wbyte[BCD_BIT]; // R19
              wflop_r[i]    <= 1'b0;
              rflop_r[i]    <= 1'b0;
              cnt_l_r[i]    <= 1'b0;
              sta_l_r[i]    <= 1'b0;
            end
          end else if (wbyte[SEL_HI:SEL_LO] == SEL_READBACK &&
                       wbyte[RB_PICK_LO + i]) begin // R16 R23
            if (!wbyte[RB_CNT_N] && !cnt_l_r[i]) begin
              hold_r[i]  <= cnt_r[i];
              cnt_l_r[i] <= 1'b1;
            end
            if (!wbyte[RB_STA_N] && !sta_l_r[i]) begin
              status_r[i] <= {out_r[i], null_r[i], cfg_r[i]}; // R24
              sta_l_r[i]  <= 1'b1;
            end
          end
        end else if (acc && hit_cnt && hit_idx == 2'(i)) begin
          if (pwrite) begin
            if (cfg_r[i].fmt == FMT_LOW) begin
              reload_r[i] <= {ZERO8, wbyte};
            end else if (cfg_r[i].fmt == FMT_HIGH) begin
              reload_r[i] <= {wbyte, ZERO8};
            end else if (!wflop_r[i]) begin
              reload_r[i][7:0] <= wbyte; // R22
              wflop_r[i]       <= 1'b1;
            end else begin
              reload_r[i][15:8] <= wbyte;
              wflop_r[i]        <= 1'b0;
            end
          end else if (sta_l_r[i]) begin
            sta_l_r[i] <= 1'b0;
          end else begin
            if (cfg_r[i].fmt == FMT_LOHI) begin
              rflop_r[i] <= ~rflop_r[i]; // R22
            end
            if (cfg_r[i].fmt != FMT_LOHI || rflop_r[i]) begin
              cnt_l_r[i] <= 1'b0;
            end
          end
        end
      end
    end
  end

  // ******************************************************************
  // Clock sources and edge detection
  // ******************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r     <= '0;
      int_clk_r <= 1'b0;
    end else if (div_r == 4'(INT_HALF - 1)) begin
      div_r     <= '0;
      int_clk_r <= ~int_clk_r; // R5
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  assign clk_src[0] = clksel_r ? ext_clk0 : int_clk_r; // R5
  assign clk_src[1] = clk1_in;
  assign clk_src[2] = out_r[1]; // R3

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q_r  <= '0;
      gate_q_r <= '0;
    end else begin
      clk_q_r  <= clk_src;
      gate_q_r <= gate;
    end
  end

  assign tick = clk_src & ~clk_q_r; // R6
  assign rise = gate & ~gate_q_r; // R6

  // ******************************************************************
  // Counting cores
  // ******************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        cnt_r[i] <= ZERO16;
        st_r[i]  <= ST_IDLE;
      end
      out_r   <= {3{OUT_RST}};
      null_r  <= '0;
      have_r  <= '0;
      trig_r  <= '0;
      extra_r <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        logic [2:0] m;
        logic       bcd;
        m   = eff_mode(cfg_r[i].mode);
        bcd = cfg_r[i].bcd;
        if (wr_ctl[i]) begin
          m         = eff_mode(wbyte[MODE_HI:MODE_LO]);
          out_r[i]  <= (m != MODE0); // R7
          st_r[i]   <= ST_IDLE;
          have_r[i] <= 1'b0;
          trig_r[i] <= 1'b0;
          null_r[i] <= 1'b1;
        end else if (wr_first[i] && m == MODE0) begin
          // Mode 0 halts between the two bytes of a new count
          st_r[i]  <= ST_IDLE;
          out_r[i] <= 1'b0; // R7
        end else if (wr_done[i]) begin
          null_r[i] <= 1'b1;
          have_r[i] <= 1'b1;
          if (m == MODE0) begin
            out_r[i] <= 1'b0; // R7
            st_r[i]  <= ST_LOAD;
          end else if (m == MODE4) begin
            st_r[i] <= ST_LOAD; // R12
          end else if ((m == MODE2 || m == MODE3) && st_r[i] != ST_RUN) begin
            st_r[i] <= ST_LOAD;
          end
        end else begin
          if (rise[i] && (m == MODE1 || m == MODE5)) begin
            trig_r[i] <= 1'b1; // R8 R14
          end
          if ((m == MODE2 || m == MODE3) && have_r[i]) begin
            if (!gate[i]) begin
              out_r[i] <= 1'b1; // R9
            end else if (rise[i]) begin
              st_r[i] <= ST_LOAD;
            end
          end
          if (tick[i]) begin
            if ((m == MODE1 || m == MODE5) && have_r[i] && (trig_r[i] || rise[i])) begin
              cnt_r[i]  <= reload_r[i]; // R8 R14
              null_r[i] <= 1'b0;
              out_r[i]  <= (m == MODE5);
              trig_r[i] <= 1'b0;
              st_r[i]   <= ST_RUN;
            end else begin
              case (st_r[i])
                ST_LOAD: begin
                  // Odd mode-3 counts load one less and stretch the high half
                  cnt_r[i]   <= (m == MODE3 && reload_r[i][0]) ? dec1(reload_r[i], bcd)
                                                                 : reload_r[i]; // R10
                  null_r[i]  <= 1'b0;
                  extra_r[i] <= 1'b0;
                  st_r[i]    <= ST_RUN;
                  if (m == MODE2 || m == MODE3) begin
                    out_r[i] <= 1'b1;
                  end
                end
                ST_RUN: begin
                  if (gate[i] || m == MODE1 || m == MODE5) begin // R13 R25
                    case (m)
                      MODE0, MODE1: begin
                        cnt_r[i] <= dec1(cnt_r[i], bcd); // R2
                        if (cnt_r[i] == ONE16) begin
                          out_r[i] <= 1'b1; // R7 R8
                          st_r[i]  <= ST_DONE;
                        end
                      end
                      MODE2: begin
                        if (cnt_r[i] == ONE16) begin
                          cnt_r[i]  <= reload_r[i]; // R9
                          null_r[i] <= 1'b0;
                          out_r[i]  <= 1'b1;
                        end else begin
                          cnt_r[i] <= dec1(cnt_r[i], bcd);
                          if (cnt_r[i] == TWO16) begin
                            out_r[i] <= 1'b0; // R9
                          end
                        end
                      end
                      MODE3: begin
                        if (cnt_r[i] == TWO16) begin
                          if (out_r[i] && reload_r[i][0] && !extra_r[i]) begin
                            extra_r[i] <= 1'b1; // R10
                          end else begin
                            out_r[i]   <= ~out_r[i]; // R10
                            extra_r[i] <= 1'b0;
                            null_r[i]  <= 1'b0;
                            cnt_r[i]   <= reload_r[i][0] ? dec1(reload_r[i], bcd)
                                                         : reload_r[i]; // R11
                          end
                        end else begin
                          cnt_r[i] <= dec1(dec1(cnt_r[i], bcd), bcd); // R11
                        end
                      end
                      default: begin
                        cnt_r[i] <= dec1(cnt_r[i], bcd);
                        if (cnt_r[i] == ONE16) begin
                          out_r[i] <= 1'b0; // R12 R14
                          st_r[i]  <= ST_DONE;
                        end
                      end
                    endcase
                  end
                end
                ST_DONE: begin
                  // Strobe modes end their single low period here
                  cnt_r[i] <= dec1(cnt_r[i], bcd);
                  if (m == MODE4 || m == MODE5) begin
                    out_r[i] <= 1'b1; // R12 R14
                    st_r[i]  <= ST_IDLE;
                  end
                end
                default: begin
                end
              endcase
            end
          end
        end
      end
    end
  end

  assign cnt_out   = out_r; // R1
  assign adc_start = out_r[2]; // R4

endmodule

// >>> sim/tic_checker.sv
// Checks on the interval counter top ports.
// Bound to tic_top from the testbench; single pclk domain.
`timescale 1ns/1ps
module tic_checker
  import tic_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              ext_clk0,
  input wire logic              clk1_in,
  input wire logic [2:0]        gate,
  input wire logic [2:0]        cnt_out,
  input wire logic              adc_start
);
  logic       acc;
  logic       mapped;
  logic       cfg_wr;
  logic [2:0] mode0_r;

  assign acc    = psel && penable;
  assign mapped = paddr inside {OFF_CNT0, OFF_CNT1, OFF_CNT2, OFF_SETUP, OFF_CLKSEL};
  assign cfg_wr = acc && pwrite && paddr == OFF_SETUP && pwdata[7:6] != SEL_READBACK
                  && pwdata[5:4] != FMT_LATCH;

  // Counter 0 mode, needed to judge its gate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mode0_r <= MODE0;
    else if (cfg_wr && pwdata[7:6] == 2'b00)
      mode0_r <= pwdata[3:1];
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_adc_follow: assert property (adc_start == cnt_out[2])
    else $error("adc_start differs from counter 2");
  chk_err_unmap: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  chk_err_quiet: assert property (!(acc && !mapped) |-> !pslverr)
    else $error("spurious pslverr");
  chk_rd_upper: assert property (prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  chk_rd_empty: assert property (acc && !pwrite && (!mapped || paddr == OFF_SETUP)
                                 |-> prdata == 32'h0000_0000)
    else $error("write-only or unmapped read not zero");
  chk_setup_out: assert property (cfg_wr |-> ##2
      cnt_out[$past(pwdata[7:6], 2)] == ($past(pwdata[3:1], 2) != MODE0))
    else $error("output level after setup wrong");
  chk_reset_idle: assert property ($rose(presetn) |-> cnt_out == 3'b000)
    else $error("outputs not idle after reset");
  chk_gate_hold: assert property ((mode0_r[1:0] == 2'b10 && !gate[0]) [*2]
                                  |-> cnt_out[0])
    else $error("rate output low with gate low");
endmodule

// >>> sim/tic_apb_host.sv
// Host model: APB master standing in for the processor.
// Shares pclk with the counter; one transfer at a time.
`timescale 1ns/1ps
module tic_apb_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released bus shows junk, so stale values never pass by luck
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

// >>> sim/tb_triple_interval_counter.sv
// Testbench: table of register cases, then timing and reset tests.
// Needs the host model and the checker; internal clock ticks each 2 pclk.
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module tb_triple_interval_counter;
  import tic_pkg::*;
  typedef struct packed {logic [7:0] ctl; logic [15:0] val;} tic_row_t;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_clk0;
  logic        clk1_in;
  logic [2:0]  gate;
  logic [2:0]  cnt_out;
  logic        adc_start;
  logic        run0;
  logic        run1;
  int          ph;
  int          fails;
  int          checks_done;
  tic_row_t    rows [6];

  tic_top u_tic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk0(ext_clk0), .clk1_in(clk1_in), .gate(gate),
    .cnt_out(cnt_out), .adc_start(adc_start));
  tic_apb_host u_tic_apb_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Pin clocks: counter 1 period 4 pclk, external period 6 pclk
  always @(posedge pclk) begin
    ph <= ph + 1;
    if (run1 && ph % 2 == 0) clk1_in <= !clk1_in;
    if (run0 && ph % 3 == 0) ext_clk0 <= !ext_clk0;
  end

  task automatic wrap_up();
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    u_tic_apb_host.xfer(1'b1, a, {24'h00_0000, d}, q, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] q;
    logic        e;
    u_tic_apb_host.xfer(1'b0, a, 32'h0000_0000, q, e);
    `CHK(q[7:0], x)
  endtask

  // Always low-then-high format, so byte pairs stay in step
  task automatic prog(input logic [1:0] c, input logic [2:0] m, input logic [15:0] n);
    wr(OFF_SETUP, {c, FMT_LOHI, m, 1'b0});
    wr({4'h0, c, 2'b00}, n[7:0]);
    wr({4'h0, c, 2'b00}, n[15:8]);
  endtask

  task automatic nxt(inout int n);
    @(posedge pclk);
    #1;
    n++;
  endtask

  // Low width and full period from one falling edge of an output
  task automatic tmeas(input int i, input int lo_e, input int per_e);
    int n;
    int lo;
    int hi;
    n = 0;
    lo = 0;
    hi = 0;
    while (n < 400 && cnt_out[i] !== 1'b1) nxt(n);
    while (n < 400 && cnt_out[i] !== 1'b0) nxt(n);
    while (n < 400 && cnt_out[i] === 1'b0) begin
      nxt(n);
      lo++;
    end
    while (n < 400 && cnt_out[i] === 1'b1) begin
      nxt(n);
      hi++;
    end
    `CHK(lo, lo_e)
    if (per_e > 0) `CHK(lo + hi, per_e)
  endtask

  initial begin
    logic [31:0] q;
    logic        e;
    tic_row_t    r;
    presetn = 1'b0;
    gate = 3'b000;
    clk1_in = 1'b0;
    ext_clk0 = 1'b0;
    run0 = 1'b0;
    run1 = 1'b0;
    ph = 0;
    fails = 0;
    checks_done = 0;
    rows = '{'{8'h10, 16'h0034}, '{8'h20, 16'h5600}, '{8'h34, 16'h1234},
             '{8'h37, 16'h0098}, '{8'h3C, 16'h0321}, '{8'h38, 16'h0200}};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      r = rows[i];
      wr(OFF_SETUP, r.ctl);
      if (r.ctl[4]) wr(OFF_CNT0, r.val[7:0]);
      if (r.ctl[5]) wr(OFF_CNT0, r.val[15:8]);
      repeat (4) @(posedge pclk);
      if (r.ctl[4]) rdchk(OFF_CNT0, r.val[7:0]);
      if (r.ctl[5]) rdchk(OFF_CNT0, r.val[15:8]);
      wr(OFF_SETUP, 8'hE2);
      rdchk(OFF_CNT0, {r.ctl[3:1] != MODE0, 1'b0, r.ctl[5:0]});
    end
    for (int k = 0; k < 2; k++) begin
      wr(OFF_SETUP, (k == 0) ? 8'h00 : 8'hD2);
      // New count lands while latched, so only the held value reads back
      wr(OFF_CNT0, 8'h00);
      wr(OFF_CNT0, 8'h03 + 8'(k));
      repeat (4) @(posedge pclk);
      rdchk(OFF_CNT0, 8'h00);
      rdchk(OFF_CNT0, 8'h02 + 8'(k));
    end
    rdchk(OFF_SETUP, 8'h00);
    prog(2'd0, MODE2, 16'h0004);
    @(posedge pclk) gate <= 3'b001;
    tmeas(0, 2, 8);
    @(posedge pclk) gate <= 3'b000;
    // Lands where a free-running count would be low again
    repeat (7) @(posedge pclk);
    #1 `CHK(cnt_out[0], 1'b1)
    prog(2'd0, MODE3, 16'h0005);
    @(posedge pclk) gate <= 3'b001;
    tmeas(0, 4, 10);
    prog(2'd0, MODE4, 16'h0003);
    tmeas(0, 2, 0);
    @(posedge pclk) gate <= 3'b000;
    prog(2'd0, MODE4, 16'h0003);
    tmeas(0, 0, 0);
    prog(2'd0, MODE1, 16'h0003);
    @(posedge pclk) gate <= 3'b001;
    tmeas(0, 6, 0);
    @(posedge pclk) gate <= 3'b000;
    prog(2'd0, MODE5, 16'h0003);
    @(posedge pclk) gate <= 3'b001;
    tmeas(0, 2, 0);
    @(posedge pclk) run1 <= 1'b1;
    gate <= 3'b110;
    prog(2'd1, MODE2, 16'h0002);
    prog(2'd2, MODE2, 16'h0003);
    tmeas(1, 4, 8);
    tmeas(2, 8, 24);
    wr(OFF_CLKSEL, 8'h01);
    rdchk(OFF_CLKSEL, 8'h01);
    prog(2'd0, MODE2, 16'h0002);
    @(posedge pclk) gate <= 3'b111;
    tmeas(0, 0, 0);
    @(posedge pclk) run0 <= 1'b1;
    tmeas(0, 6, 12);
    prog(2'd0, MODE0, 16'h0003);
    #1 `CHK(cnt_out[0], 1'b0)
    repeat (30) @(posedge pclk);
    #1 `CHK(cnt_out[0], 1'b1)
    @(posedge pclk) presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    `CHK(cnt_out, 3'b000)
    @(posedge pclk) presetn <= 1'b1;
    rdchk(OFF_CLKSEL, 8'h00);
    u_tic_apb_host.xfer(1'b0, 8'h14, 32'h0000_0000, q, e);
    `CHK(e, 1'b1)
    `CHK(q, 32'h0000_0000)
    wrap_up();
  end

  initial begin
    #2_000_000;
    fails++;
    wrap_up();
  end
endmodule

bind tic_top tic_checker #(.ADDR_W(ADDR_W)) u_tic_checker (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_clk0(ext_clk0), .clk1_in(clk1_in), .gate(gate), .cnt_out(cnt_out),
  .adc_start(adc_start));
